// ---- spi_cfg_decode.v ----
// Serial command decoder into five write-only configuration registers.
// Function
// - Each transaction writes one of five registers unless bits 19:18 are 01.
// - Address bits 19,18 select target register; bit 17 too unless they are 00.
// - Step-disable bit picks drive-control layout.
// - Chopper fields mapped from command bits.
// - Adaptive current fields mapped from command bits.
// - Load sense fields mapped from command bits.
// - Driver configuration fields mapped from command.
// - Step layout: interpolation, dual edge, resolution.
// - Direct layout: coil currents from command.
// - Bit 17 sets coil A polarity.
// - Bit 8 sets coil B polarity.
// - Coil A magnitude from bits 16:9.
// - Coil B magnitude from bits 7:0.
// - Select 00: position, zeros, status flags.
// - Select 01: load measurement; 10: load bits 9:5, current scale.
// - Select 11: diagnostics, bits 9:8 ones.
// - Chip select rise latches last 20 bits.
// - Sample on rising, shift out after falling.
// - Extra bits leave delayed twenty clocks.
`timescale 1ns/1ps
`include "spi_cfg_consts.vh"
// How the block works, in short.
// The three serial pins cross into the mclk domain through pin_sync, so
// every edge on them is seen three to four mclk cycles late. Each half of
// the link clock must therefore last several mclk periods.
// While the select is low, each rising link clock edge shifts one bit in
// and each falling edge puts the next bit of the shifter on the output.
// The shifter is loaded with the response word when the select falls, so
// the host reads status while it writes its command.
// When the select rises, the last twenty bits in the shifter are decoded
// and, unless bits 19:18 are 01, written into one of the five registers; there is no
// read command, and every frame is a write.
// The drive-control word is kept raw and decoded in a separate stage, so
// a change of layout takes effect on the stored word without a rewrite.
// All outputs are registered, so logic downstream sees clean levels.
module spi_cfg_decode (
   // System clock and reset.
   input  wire       mclk,
   input  wire       reset_n,
   // Serial link pins from the host, all asynchronous to mclk.
   input  wire       sck,
   input  wire       sdi,
   input  wire       csn,
   // Serial response back to the host and its enable.
   output reg        sdo,
   output reg        sdo_oe,
   // Live status offered to the read response, already on mclk.
   input  wire [9:0] microstep_position,
   input  wire [9:0] load_measurement,
   input  wire [4:0] actual_current_scale,
   input  wire [7:0] status_flags,
   input  wire [9:0] diag_flags,
   // Layout select, then the drive-control fields of both layouts.
   output reg        step_input_disable,
   output reg        step_interpolation_enable,
   output reg        dual_edge_step,
   output reg  [3:0] microstep_resolution,
   output reg        coil_a_polarity,
   output reg  [7:0] coil_a_magnitude,
   output reg        coil_b_polarity,
   output reg  [7:0] coil_b_magnitude,
   // Chopper fields.
   output reg  [1:0] blanking_time,
   output reg        chopper_mode_select,
   output reg        random_off_time,
   output reg  [1:0] hysteresis_decrement,
   output reg  [3:0] hysteresis_end,
   output reg  [2:0] hysteresis_start,
   output reg  [3:0] off_time,
   // Load-adaptive current fields.
   output reg        min_current_select,
   output reg  [1:0] current_decrement_speed,
   output reg  [3:0] upper_load_threshold,
   output reg  [1:0] current_increment_step,
   output reg  [3:0] lower_load_threshold,
   // Load sensing fields.
   output reg        load_filter_enable,
   output reg  [6:0] load_threshold,
   output reg  [4:0] current_scale,
   // Driver configuration fields.
   output reg        test_mode,
   output reg  [1:0] high_side_slope,
   output reg  [1:0] low_side_slope,
   output reg        slope_msb,
   output reg        ground_short_disable,
   output reg  [1:0] short_detect_delay,
   output reg        sense_full_scale,
   output reg  [1:0] readback_select,
   output reg        overtemp_threshold_select,
   output reg        short_sensitivity,
   output reg        passive_fast_decay_enable,
   output reg        supply_short_enable,
   // One-cycle pulse for each committed frame.
   output reg        write_strobe
);
   // Synchronised pin levels.
   // Each pin passes three flops; a level counts once two stages agree,
   // which also filters out single-cycle glitches on the pins.
   wire sck_s;
   wire sdi_s;
   wire csn_s;

   // Link clock; it idles high between frames.
   pin_sync #(
      .RESET_LEVEL (1'b1)
   ) u_sync_sck (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .pin_in      (sck),
      .level_q     (sck_s)
   );
   // Serial data in; only its level at a rising clock edge matters.
   pin_sync #(
      .RESET_LEVEL (1'b1)
   ) u_sync_sdi (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .pin_in      (sdi),
      .level_q     (sdi_s)
   );
   // Select; it idles high, so reset must not look like a frame start.
   pin_sync #(
      .RESET_LEVEL (1'b1)
   ) u_sync_csn (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .pin_in      (csn),
      .level_q     (csn_s)
   );

   // Edge history, the shifter and the raw drive-control word.
   reg                   sck_prev_q;   // Last synchronised clock level.
   reg                   csn_prev_q;   // Last synchronised select level.
   reg [`WORD_BITS-1:0]  shift_q;      // Twenty-bit shift register.
   reg [`WORD_BITS-1:0]  resp_d;       // Response word built from status.
   reg [`WORD_BITS-1:0]  drive_ctrl_q; // Raw drive-control word.

   // Edge strobes, each high for exactly one mclk cycle.
   wire sck_rise = sck_s & ~sck_prev_q;
   wire sck_fall = ~sck_s & sck_prev_q;
   wire cs_fall  = ~csn_s & csn_prev_q;
   wire cs_rise  = csn_s & ~csn_prev_q;

   // Response layout follows the select field held before this frame.
   // The word is built every cycle from live status; it is only copied
   // into the shifter on a select fall, so status that moves later in the
   // frame is not seen until the next frame. The low byte is the same
   // status byte in every layout, so a host can poll it in any mode.
   always @* begin
      resp_d = `WORD_RESET;
      case (readback_select)
         `READBACK_SELECT_POSITION: begin
            resp_d = {microstep_position, 2'b00, status_flags};
         end
         `READBACK_SELECT_LOAD: begin
            resp_d = {load_measurement, 2'b00, status_flags};
         end
         `READBACK_SELECT_LOAD_SCALE: begin
            resp_d = {load_measurement[9:5], actual_current_scale,
                      2'b00, status_flags};
         end
         `READBACK_SELECT_DIAG: begin
            resp_d = {diag_flags, 2'b11, status_flags};
         end
         default: begin
            resp_d = `WORD_RESET;
         end
      endcase
   end

   // Edge tracking of the synchronised serial pins.
   // Both history flops reset high, the idle level of the clock and select
   // pins, so releasing reset never looks like an edge.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sck_prev_q <= 1'b1;
         csn_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         csn_prev_q <= csn_s;
      end
   end

   // Shift path. Loading at select fall means the response appears first,
   // and bits shifted in come out twenty clocks later for daisy chains.
   // The output moves on select fall and a few mclk cycles after a falling link clock edge;
   // the host samples half a bit after that edge, so its setup is half a period less the synchroniser lag.
   // The enable follows the synchronised select, one cycle late.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         shift_q <= `WORD_RESET;
         sdo     <= 1'b0;
         sdo_oe  <= 1'b0;
      end else begin
         sdo_oe <= ~csn_s;
         if (cs_fall) begin
            shift_q <= resp_d;
            sdo     <= resp_d[`WORD_BITS-1];
         end else if (!csn_s && sck_rise) begin
            // MSB first; sampled on the rising edge.
            shift_q <= {shift_q[`WORD_BITS-2:0], sdi_s};
         end else if (!csn_s && sck_fall) begin
            sdo <= shift_q[`WORD_BITS-1];
         end
      end
   end

   // Commit on select rise; only the last twenty bits remain in the shifter.
   // A short frame is committed anyway, since the host owns that contract.
   // Each field keeps its value until a frame for its own register
   // arrives; the strobe marks every commit, whatever the target.
   // Address pattern 01 matches no register and only pulses the strobe.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         // All fields leave reset as zero, the quiet idle setting.
         drive_ctrl_q              <= `WORD_RESET;
         write_strobe              <= 1'b0;
         blanking_time             <= 2'b00;
         chopper_mode_select       <= 1'b0;
         random_off_time           <= 1'b0;
         hysteresis_decrement      <= 2'b00;
         hysteresis_end            <= 4'h0;
         hysteresis_start          <= 3'h0;
         off_time                  <= 4'h0;
         min_current_select        <= 1'b0;
         current_decrement_speed   <= 2'b00;
         upper_load_threshold      <= 4'h0;
         current_increment_step    <= 2'b00;
         lower_load_threshold      <= 4'h0;
         load_filter_enable        <= 1'b0;
         load_threshold            <= 7'h00;
         current_scale             <= 5'h00;
         test_mode                 <= 1'b0;
         high_side_slope           <= 2'b00;
         low_side_slope            <= 2'b00;
         slope_msb                 <= 1'b0;
         ground_short_disable      <= 1'b0;
         short_detect_delay        <= 2'b00;
         step_input_disable        <= 1'b0;
         sense_full_scale          <= 1'b0;
         readback_select           <= 2'b00;
         overtemp_threshold_select <= 1'b0;
         short_sensitivity         <= 1'b0;
         passive_fast_decay_enable <= 1'b0;
         supply_short_enable       <= 1'b0;
      end else begin
         write_strobe <= cs_rise;
         if (cs_rise) begin
            if (shift_q[`ADDR_HI:`ADDR_MID] == `SEL_DRIVE_CTRL) begin
               drive_ctrl_q <= shift_q;
            end else begin
               // The other four registers need all three address bits.
               case (shift_q[`ADDR_HI:`ADDR_LO])
                  `SEL_CHOPPER: begin
                     blanking_time        <= shift_q[16:15];
                     chopper_mode_select  <= shift_q[14];
                     random_off_time      <= shift_q[13];
                     hysteresis_decrement <= shift_q[12:11];
                     hysteresis_end       <= shift_q[10:7];
                     hysteresis_start     <= shift_q[6:4];
                     off_time             <= shift_q[3:0];
                  end
                  `SEL_ADAPTIVE: begin
                     // Bits 16, 12, 7 and 4 are fixed zero and unused.
                     min_current_select      <= shift_q[15];
                     current_decrement_speed <= shift_q[14:13];
                     upper_load_threshold    <= shift_q[11:8];
                     current_increment_step  <= shift_q[6:5];
                     lower_load_threshold    <= shift_q[3:0];
                  end
                  `SEL_LOAD_SENSE: begin
                     // Bits 15 and 7:5 are fixed zero and unused.
                     load_filter_enable <= shift_q[16];
                     load_threshold     <= shift_q[14:8];
                     current_scale      <= shift_q[4:0];
                  end
                  `SEL_DRIVER_CFG: begin
                     test_mode                 <= shift_q[16];
                     high_side_slope           <= shift_q[15:14];
                     low_side_slope            <= shift_q[13:12];
                     slope_msb                 <= shift_q[11];
                     ground_short_disable      <= shift_q[10];
                     short_detect_delay        <= shift_q[9:8];
                     // The layout bit also changes the drive-control decode.
                     step_input_disable        <= shift_q[`STEP_DISABLE_BIT];
                     sense_full_scale          <= shift_q[6];
                     // A new select only shapes the next frame's response.
                     readback_select <= shift_q[`READBACK_SELECT_HI:`READBACK_SELECT_LO];
                     overtemp_threshold_select <= shift_q[3];
                     short_sensitivity         <= shift_q[2];
                     passive_fast_decay_enable <= shift_q[1];
                     supply_short_enable       <= shift_q[0];
                  end
                  default: begin
                     // Address pattern 01 matches no register; nothing is written.
                     blanking_time <= blanking_time;
                  end
               endcase
            end
         end
      end
   end

   // Drive-control fields decoded by the current layout; the word is kept
   // raw so a later layout change reinterprets the last write.
   // Fields of the layout that is not selected read as zero, so logic
   // downstream never acts on a stale field of the other layout.
   // The cost is one cycle of lag after either the word or the layout bit.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         step_interpolation_enable <= 1'b0;
         dual_edge_step            <= 1'b0;
         microstep_resolution      <= 4'h0;
         coil_a_polarity           <= 1'b0;
         coil_a_magnitude          <= 8'h00;
         coil_b_polarity           <= 1'b0;
         coil_b_magnitude          <= 8'h00;
      end else if (step_input_disable) begin
         step_interpolation_enable <= 1'b0;
         dual_edge_step            <= 1'b0;
         microstep_resolution      <= 4'h0;
         coil_a_polarity           <= drive_ctrl_q[17];
         coil_a_magnitude          <= drive_ctrl_q[16:9];
         coil_b_polarity           <= drive_ctrl_q[8];
         coil_b_magnitude          <= drive_ctrl_q[7:0];
      end else begin
         step_interpolation_enable <= drive_ctrl_q[9];
         dual_edge_step            <= drive_ctrl_q[8];
         microstep_resolution      <= drive_ctrl_q[3:0];
         coil_a_polarity           <= 1'b0;
         coil_a_magnitude          <= 8'h00;
         coil_b_polarity           <= 1'b0;
         coil_b_magnitude          <= 8'h00;
      end
   end
endmodule

// ---- spi_cfg_consts.vh ----
// Constants for the serial configuration register decoder.
`ifndef SPI_CFG_CONSTS_VH
`define SPI_CFG_CONSTS_VH
`define WORD_BITS        20
`define CNT_BITS         5
`define ADDR_HI          19
`define ADDR_MID         18
`define ADDR_LO          17
`define SEL_DRIVE_CTRL   2'b00
`define SEL_CHOPPER      3'b100
`define SEL_ADAPTIVE     3'b101
`define SEL_LOAD_SENSE   3'b110
`define SEL_DRIVER_CFG   3'b111
`define STEP_DISABLE_BIT 7
`define READBACK_SELECT_HI         5
`define READBACK_SELECT_LO         4
`define READBACK_SELECT_POSITION   2'b00
`define READBACK_SELECT_LOAD       2'b01
`define READBACK_SELECT_LOAD_SCALE 2'b10
`define READBACK_SELECT_DIAG       2'b11
`define DRV_CFG_RESET    20'h00000
`define WORD_RESET       20'h00000
`endif

// ---- pin_sync.v ----
// Three-stage pin synchroniser with agreement between stages two and three.
`timescale 1ns/1ps
module pin_sync #(
   parameter RESET_LEVEL = 1'b1   // Idle level of the pin, taken in reset.
) (
   input  wire mclk,
   input  wire reset_n,
   input  wire pin_in,
   output reg  level_q
);
   reg s1_q;   // First stage, read only by the second.
   reg s2_q;   // Second stage.
   reg s3_q;   // Third stage.

   // The level only moves once the two settled stages agree.
   // Reset loads the parameter, a constant, into every stage.
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q    <= RESET_LEVEL;
         s2_q    <= RESET_LEVEL;
         s3_q    <= RESET_LEVEL;
         level_q <= RESET_LEVEL;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule

// ---- spi_host.sv ----
// Host model that masters the serial link in clock-idle-high mode.
`timescale 1ns/1ps
module spi_host (
   output reg  sck,
   output reg  sdi,
   output reg  csn,
   input  wire sdo
);
   // The link clock stands high and the select is off between frames.
   initial begin
      sck = 1'b1;
      sdi = 1'b1;
      csn = 1'b1;
   end
   // Sends n bits MSB first at 80 ns a bit; r holds what came back.
   task xfer(input [31:0] w, input integer n, output [31:0] r);
      integer i;
      begin
         r = 32'h0;
         csn = 1'b0;
         #100;
         for (i = n - 1; i >= 0; i = i - 1) begin
            sck = 1'b0;
            sdi = w[i];
            #40;
            r[i] = sdo;
            sck = 1'b1;
            #40;
         end
         csn = 1'b1;
         // Flip the data line so a stale level cannot look valid.
         sdi = ~sdi;
         #150;
      end
   endtask
endmodule

// ---- spi_cfg_decode_assertions.sv ----
// Concurrent checks on the ports of the serial configuration decoder.
`timescale 1ns/1ps
module spi_cfg_decode_checker (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic       csn,
   input wire logic       sdo_oe,
   input wire logic       write_strobe,
   input wire logic       step_input_disable,
   input wire logic       step_interpolation_enable,
   input wire logic       dual_edge_step,
   input wire logic [3:0] microstep_resolution,
   input wire logic       coil_a_polarity,
   input wire logic [7:0] coil_a_magnitude,
   input wire logic       coil_b_polarity,
   input wire logic [7:0] coil_b_magnitude,
   input wire logic [3:0] off_time,
   input wire logic [1:0] blanking_time,
   input wire logic [1:0] readback_select
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // The select pin passes a synchroniser, so the commit lags a few cycles.
   sequence cs_rise_s;
      $rose(csn);
   endsequence
   sequence commit_s;
      ##[2:8] write_strobe;
   endsequence
   a_select_commit: assert property (cs_rise_s |-> commit_s)
      else $error("no commit after select rise");
   a_strobe_single: assert property (write_strobe |=> !write_strobe)
      else $error("strobe longer than one cycle");
   a_strobe_deselect: assert property (write_strobe |-> csn && $past(csn))
      else $error("strobe while selected");
   a_oe_idle_off: assert property (csn [*8] |-> !sdo_oe)
      else $error("output enabled while deselected");
   a_oe_frame_on: assert property (!csn [*8] |-> sdo_oe)
      else $error("output not enabled in frame");
   a_cfg_hold: assert property ($changed({off_time, blanking_time})
      |-> write_strobe)
      else $error("chopper fields moved without a commit");
   a_select_hold: assert property ($changed(readback_select)
      |-> write_strobe)
      else $error("readback select moved without a commit");
   a_step_fields_off: assert property (step_input_disable
      && $past(step_input_disable) |-> {step_interpolation_enable,
      dual_edge_step, microstep_resolution} == 6'h00)
      else $error("step layout fields live in direct layout");
   a_coil_fields_off: assert property (!step_input_disable
      && !$past(step_input_disable) |-> {coil_a_polarity, coil_a_magnitude,
      coil_b_polarity, coil_b_magnitude} == 18'h00000)
      else $error("coil fields live in step layout");
endmodule
bind spi_cfg_decode spi_cfg_decode_checker spi_cfg_decode_checker_i (
   .mclk, .reset_n, .csn, .sdo_oe, .write_strobe, .step_input_disable,
   .step_interpolation_enable, .dual_edge_step, .microstep_resolution,
   .coil_a_polarity, .coil_a_magnitude, .coil_b_polarity, .coil_b_magnitude,
   .off_time, .blanking_time, .readback_select);

// ---- test_spi_cfg_decode.sv ----
// Self-checking bench for the serial configuration decoder.
`timescale 1ns/1ps
module test_spi_cfg_decode;
   reg         mclk;
   reg         reset_n;
   reg  [9:0]  mp, lm, dg;  // Status words offered to the response.
   reg  [4:0]  acs;         // Actual current scale shown in the response.
   reg  [7:0]  st;          // Status flags of the low response byte.
   reg  [31:0] rsp;         // Bits the host saw on the serial output.
   reg  [1:0]  p;           // Select that the previous frame left behind.
   integer     error_cnt, comparisons;
   wire sck, sdi, csn, sdo, sdo_oe, step_input_disable, write_strobe;
   wire step_interpolation_enable, dual_edge_step, coil_a_polarity;
   wire coil_b_polarity, chopper_mode_select, random_off_time, slope_msb;
   wire min_current_select, load_filter_enable, test_mode, sense_full_scale;
   wire ground_short_disable, overtemp_threshold_select, short_sensitivity;
   wire passive_fast_decay_enable, supply_short_enable;
   wire [1:0] blanking_time, hysteresis_decrement, current_decrement_speed;
   wire [1:0] current_increment_step, high_side_slope, low_side_slope;
   wire [1:0] short_detect_delay, readback_select;
   wire [2:0] hysteresis_start;
   wire [3:0] microstep_resolution, hysteresis_end, off_time;
   wire [3:0] upper_load_threshold, lower_load_threshold;
   wire [4:0] current_scale;
   wire [6:0] load_threshold;
   wire [7:0] coil_a_magnitude, coil_b_magnitude;
   spi_cfg_decode spi_cfg_decode_i (.mclk, .reset_n, .sck, .sdi, .csn,
      .sdo, .sdo_oe, .microstep_position(mp), .load_measurement(lm),
      .actual_current_scale(acs), .status_flags(st), .diag_flags(dg),
      .step_input_disable, .step_interpolation_enable, .dual_edge_step,
      .microstep_resolution, .coil_a_polarity, .coil_a_magnitude,
      .coil_b_polarity, .coil_b_magnitude, .blanking_time,
      .chopper_mode_select, .random_off_time, .hysteresis_decrement,
      .hysteresis_end, .hysteresis_start, .off_time, .min_current_select,
      .current_decrement_speed, .upper_load_threshold,
      .current_increment_step, .lower_load_threshold, .load_filter_enable,
      .load_threshold, .current_scale, .test_mode, .high_side_slope,
      .low_side_slope, .slope_msb, .ground_short_disable,
      .short_detect_delay, .sense_full_scale, .readback_select,
      .overtemp_threshold_select, .short_sensitivity,
      .passive_fast_decay_enable, .supply_short_enable, .write_strobe);
   // The output line has no pull; while it is not driven the host sees the
   // inverse of the last level, so a read outside the enable shows up.
   wire sdo_line = sdo_oe ? sdo : ~sdo;
   spi_host spi_host_i (.sck, .sdi, .csn, .sdo(sdo_line));
   // The 200 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Counts one comparison and reports a mismatch at once.
   task chk(input ok, input string m);
      comparisons = comparisons + 1;
      if (ok !== 1'b1) begin
         error_cnt = error_cnt + 1;
         $display("[ERR] %0t mismatch in %0s", $time, m);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task close_out;
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // One 20-bit frame; fixed positions always carry their fixed values.
   task wr(input [19:0] w);
      spi_host_i.xfer({12'h000, w}, 20, rsp);
   endtask
   // Driver configuration word with the layout and select chosen.
   function [19:0] cfg(input sd, input [1:0] sel);
      cfg = {3'b111, 1'b1, 2'b10, 2'b01, 1'b1, 1'b0, 2'b11, sd, 1'b1, sel,
         4'b1010};
   endfunction
   // Response expected for a select value, from the status inputs.
   function [19:0] resp(input [1:0] sel);
      case (sel)
         2'd0: resp = {mp, 2'b00, st};
         2'd1: resp = {lm, 2'b00, st};
         2'd2: resp = {lm[9:5], acs, 2'b00, st};
         default: resp = {dg, 2'b11, st};
      endcase
   endfunction
   task s_regs;
      wr({3'b100, 2'b10, 1'b1, 1'b0, 2'b01, 4'hb, 3'h5, 4'h6});
      chk({blanking_time, chopper_mode_select, random_off_time,
         hysteresis_decrement, hysteresis_end, hysteresis_start,
         off_time} === 17'h14dd6, "chopper");
      wr({3'b101, 1'b0, 1'b1, 2'b10, 1'b0, 4'h9, 1'b0, 2'b11, 1'b0, 4'h3});
      chk({min_current_select, current_decrement_speed, upper_load_threshold,
         current_increment_step, lower_load_threshold} === 13'h1a73,
         "adaptive");
      wr({3'b110, 1'b1, 1'b0, 7'h5a, 3'b000, 5'h13});
      chk({load_filter_enable, load_threshold, current_scale} === 13'h1b53,
         "load sense");
      chk({off_time, hysteresis_end} === 8'h6b, "cross write");
      wr(cfg(1'b0, 2'd0));
      chk({test_mode, high_side_slope, low_side_slope, slope_msb,
         ground_short_disable, short_detect_delay, step_input_disable,
         sense_full_scale, readback_select, overtemp_threshold_select,
         short_sensitivity, passive_fast_decay_enable,
         supply_short_enable} === (cfg(1'b0, 2'd0) & 20'h1ffff),
         "driver cfg");
   endtask
   task s_step;
      wr({2'b00, 8'h00, 2'b11, 4'h0, 4'h5});
      chk({step_interpolation_enable, dual_edge_step,
         microstep_resolution} === 6'h35, "step layout");
   endtask
   // Each frame answers in the layout chosen before it.
   task s_readback;
      p = 2'd0;
      repeat (4) begin
         wr(cfg(1'b0, p + 2'd1));
         chk(rsp[19:0] === resp(p), "response");
         p = p + 2'd1;
      end
   endtask
   // Bit 8 is set so a step-layout slip would show up.
   task s_direct;
      wr(cfg(1'b1, 2'd0));
      wr({2'b00, 1'b1, 8'hf7, 1'b1, 8'h3c});
      chk({coil_a_polarity, coil_a_magnitude} === 9'h1f7,
         "coil a");
      chk({coil_b_polarity, coil_b_magnitude} === 9'h13c,
         "coil b");
      chk({step_interpolation_enable, dual_edge_step,
         microstep_resolution} === 6'h00, "direct layout");
   endtask
   // A 28-bit frame: the first 8 bits must come back 20 clocks later.
   task s_long;
      spi_host_i.xfer({4'h0, 8'ha5, 3'b100, 17'h0a5c3}, 28, rsp);
      chk({blanking_time, chopper_mode_select, random_off_time,
         hysteresis_decrement, hysteresis_end, hysteresis_start,
         off_time} === 17'h0a5c3, "last bits");
      chk(rsp[7:0] === 8'ha5, "chain delay");
      chk(rsp[27:8] === resp(2'd0), "long response");
   endtask
   // Cuts a hang short.
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t run did not finish", $time);
      close_out;
   end
   initial begin
      error_cnt = 0;
      comparisons = 0;
      reset_n = 1'b0;
      mp = 10'h2a5;
      lm = 10'h1c3;
      dg = 10'h35a;
      acs = 5'h19;
      st = 8'h96;
      repeat (6) @(posedge mclk);
      #1 reset_n = 1'b1;
      repeat (8) @(posedge mclk);
      // Host delays are whole mclk periods, so this keeps pins off the edge.
      #1;
      s_regs;
      s_step;
      s_readback;
      s_direct;
      s_long;
      close_out;
   end
endmodule
